// file: epp_consts.svh
// timing and field constants for the eprom programming controller
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH
`define EPP_CLK_NS 50
`define EPP_SETUP_US 2
`define EPP_SETUP_CYC ((`EPP_SETUP_US * 1000 + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_PULSE_US 1000
`define EPP_PULSE_CYC ((`EPP_PULSE_US * 1000 + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_OE_NS 150
`define EPP_OE_CYC ((`EPP_OE_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_BIT_A4 4
`define EPP_BIT_A6 6
`define EPP_BIT_Q8 7
`define EPP_ERASED_BYTE 8'hff
`define EPP_CNT_W 16
`endif

// file: epp_pkg.sv
// types for the eprom programming controller
package epp_pkg;
	typedef enum logic [2:0]
	{
		EPP_OP_PROGRAM = 3'h0,
		EPP_OP_VERIFY = 3'h1,
		EPP_OP_READ = 3'h2,
		EPP_OP_PROT_PROG = 3'h3,
		EPP_OP_PROT_VERIFY = 3'h4,
		EPP_OP_DISABLE = 3'h5
	} epp_op_t;
	typedef struct packed
	{
		epp_op_t op;
		logic [12:0] addr;
		logic [7:0] data;
	} epp_req_t;
	typedef struct packed
	{
		logic chip_select_n;
		logic read_select_n;
		logic program_strobe_n;
		logic vpp_high;
		logic test_mode_select;
		logic processor_reset_n;
		logic processor_clock_in;
		logic [12:0] byte_addr;
	} epp_pins_t;
	typedef enum logic [4:0]
	{
		EPP_IDLE = 5'h01,
		EPP_SETUP = 5'h02,
		EPP_PULSE = 5'h04,
		EPP_HOLD = 5'h08,
		EPP_DONE = 5'h10
	} epp_state_t;
endpackage

// file: epp_count.sv
// down counter that times setup, pulse and hold phases
`timescale 1ns/1ps
`include "epp_consts.svh"
module epp_count
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [`EPP_CNT_W-1:0] value_in,
	output logic zero_out
);
	logic [`EPP_CNT_W-1:0] cnt_r;
	// --------------------------------
	// countdown
	// --------------------------------
	// load wins over counting so a new phase always starts cleanly
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cnt_r <= '0;
		else if (load_in)
			cnt_r <= value_in;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end
	assign zero_out = (cnt_r == '0);
endmodule

// file: epp_ctrl.sv
// programmer-side controller that drives the eprom programming pins
// Operation
// - program: data driven, select low, read high, vpp on, strobe pulsed low
// - verify: select low, strobe high, vpp on, read select pulsed low
// - read: select low, read select pulsed low, vpp at normal level
// - protect program: all selects high, test at vpp, a4 high, pulse q8
// - protect verify: select and read low, strobe high, test at vpp, a6 low
// - erase, program, verify, then program and verify protect bit
`timescale 1ns/1ps
`include "epp_consts.svh"
module epp_ctrl
	import epp_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic req_valid_in,
	input wire epp_pkg::epp_req_t req_in,
	input wire logic [7:0] byte_lines_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [7:0] rd_data_out,
	output logic mismatch_out,
	output epp_pkg::epp_pins_t pins_out,
	output logic [7:0] byte_lines_out,
	output logic [7:0] byte_lines_oe_out
);
	import epp_pkg::*;
	logic rst_meta_r, rst_r;
	logic [7:0] q_meta_r, q_sync_r;
	epp_state_t state_r, state_nxt;
	epp_req_t req_r;
	epp_pins_t pins_r, pins_nxt;
	logic [7:0] dout_r, dout_nxt, oe_r, oe_nxt;
	logic done_r, ready_r, mis_r;
	logic [7:0] rd_r;
	logic cnt_load, cnt_zero;
	logic [`EPP_CNT_W-1:0] cnt_val;
	// --------------------------------
	// reset release and pin synchronisers
	// --------------------------------
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_meta_r <= 1'b0;
			rst_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_r <= rst_meta_r;
		end
	end
	// byte lines come from the device pins, so two stages first
	always_ff @(posedge core_clk_in or negedge rst_r)
	begin
		if (!rst_r)
		begin
			q_meta_r <= 8'h00;
			q_sync_r <= 8'h00;
		end
		else
		begin
			q_meta_r <= byte_lines_in;
			q_sync_r <= q_meta_r;
		end
	end
	// --------------------------------
	// mode level decode
	// --------------------------------
	function automatic epp_pins_t mode_pins(input epp_op_t op, input logic [12:0] a,
		input logic strobe);
		epp_pins_t p;
		p = '0;
		p.processor_reset_n = 1'b0;
		p.processor_clock_in = 1'b0;
		p.byte_addr = a;
		case (op)
			EPP_OP_PROGRAM:
			begin
				p.read_select_n = 1'b1;
				p.program_strobe_n = !strobe;
				p.vpp_high = 1'b1;
			end
			EPP_OP_VERIFY:
			begin
				p.read_select_n = !strobe;
				p.program_strobe_n = 1'b1;
				p.vpp_high = 1'b1;
			end
			EPP_OP_READ:
			begin
				p.read_select_n = !strobe;
				p.program_strobe_n = 1'b1;
			end
			EPP_OP_PROT_VERIFY:
			begin
				p.program_strobe_n = 1'b1;
				p.test_mode_select = 1'b1;
				p.byte_addr = 13'h0000;
				p.byte_addr[`EPP_BIT_A6] = 1'b0;
			end
			EPP_OP_PROT_PROG:
			begin
				p.chip_select_n = 1'b1;
				p.read_select_n = 1'b1;
				p.program_strobe_n = 1'b1;
				p.vpp_high = 1'b1;
				p.test_mode_select = 1'b1;
				p.byte_addr = 13'h0000;
				p.byte_addr[`EPP_BIT_A4] = 1'b1;
			end
			default:
			begin
				p.chip_select_n = 1'b1;
				p.read_select_n = 1'b1;
				p.program_strobe_n = 1'b1;
			end
		endcase
		return p;
	endfunction
	wire in_pulse = (state_r == EPP_PULSE);
	wire is_prog = (req_r.op == EPP_OP_PROGRAM);
	wire is_pprog = (req_r.op == EPP_OP_PROT_PROG);
	wire is_rd = (req_r.op == EPP_OP_VERIFY) || (req_r.op == EPP_OP_READ)
		|| (req_r.op == EPP_OP_PROT_VERIFY);
	wire long_pulse = is_prog || is_pprog;
	wire [`EPP_CNT_W-1:0] setup_cyc = `EPP_CNT_W'(`EPP_SETUP_CYC);
	wire [`EPP_CNT_W-1:0] pulse_cyc = long_pulse ? `EPP_CNT_W'(`EPP_PULSE_CYC)
		: `EPP_CNT_W'(`EPP_OE_CYC + 2);
	// --------------------------------
	// sequencer: setup, strobe pulse, hold
	// --------------------------------
	always_comb
	begin
		state_nxt = state_r;
		cnt_load = 1'b0;
		cnt_val = setup_cyc;
		case (state_r)
			EPP_IDLE:
				if (req_valid_in)
				begin
					state_nxt = EPP_SETUP;
					cnt_load = 1'b1;
				end
			EPP_SETUP:
				if (cnt_zero)
				begin
					state_nxt = (req_r.op == EPP_OP_DISABLE) ? EPP_DONE : EPP_PULSE;
					cnt_load = 1'b1;
					cnt_val = pulse_cyc;
				end
			EPP_PULSE:
				if (cnt_zero)
				begin
					state_nxt = EPP_HOLD;
					cnt_load = 1'b1;
				end
			EPP_HOLD:
				if (cnt_zero)
					state_nxt = EPP_DONE;
			EPP_DONE:
				state_nxt = EPP_IDLE;
			default:
				state_nxt = EPP_IDLE;
		endcase
	end
	epp_count u_cnt
	(
		.clk_in(core_clk_in),
		.rst_n_in(rst_r),
		.load_in(cnt_load),
		.value_in(cnt_val),
		.zero_out(cnt_zero)
	);
	// pin levels; data driven only when writing, q8 alone pulsed for protect
	always_comb
	begin
		pins_nxt = mode_pins(state_r == EPP_IDLE ? EPP_OP_DISABLE : req_r.op,
			req_r.addr, in_pulse);
		dout_nxt = req_r.data;
		oe_nxt = 8'h00;
		if (state_r != EPP_IDLE && is_prog)
			oe_nxt = 8'hff;
		if (state_r != EPP_IDLE && is_pprog)
		begin
			oe_nxt[`EPP_BIT_Q8] = 1'b1;
			dout_nxt = 8'hff;
			dout_nxt[`EPP_BIT_Q8] = !in_pulse;
		end
	end
	// --------------------------------
	// registers
	// --------------------------------
	always_ff @(posedge core_clk_in or negedge rst_r)
	begin
		if (!rst_r)
		begin
			state_r <= EPP_IDLE;
			req_r <= '0;
			pins_r <= mode_pins(EPP_OP_DISABLE, 13'h0000, 1'b0);
			dout_r <= 8'h00;
			oe_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == EPP_IDLE && req_valid_in)
				req_r <= req_in;
			pins_r <= pins_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
		end
	end
	// answer side: sample at end of output-enable pulse
	always_ff @(posedge core_clk_in or negedge rst_r)
	begin
		if (!rst_r)
		begin
			rd_r <= `EPP_ERASED_BYTE;
			mis_r <= 1'b0;
			done_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			done_r <= (state_r == EPP_DONE);
			ready_r <= (state_nxt == EPP_IDLE);
			if (in_pulse && cnt_zero && is_rd)
			begin
				rd_r <= q_sync_r;
				mis_r <= (req_r.op == EPP_OP_VERIFY) && (q_sync_r != req_r.data);
			end
		end
	end
	assign req_ready_out = ready_r;
	assign done_out = done_r;
	assign rd_data_out = rd_r;
	assign mismatch_out = mis_r;
	assign pins_out = pins_r;
	assign byte_lines_out = dout_r;
	assign byte_lines_oe_out = oe_r;
	// --------------------------------
	// checks
	// --------------------------------
	sequence s_prog_strobe;
		!pins_r.program_strobe_n && !pins_r.chip_select_n;
	endsequence
	AST_PROG_LEVELS: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		s_prog_strobe |-> pins_r.read_select_n && pins_r.vpp_high && oe_r == 8'hff)
		else $error("program strobe without program levels");
	AST_INHIBIT: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		pins_r.chip_select_n |-> pins_r.program_strobe_n)
		else $error("strobe low while select high");
	AST_FLOAT: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		(pins_r.chip_select_n && pins_r.read_select_n && !pins_r.test_mode_select)
		|-> oe_r == 8'h00)
		else $error("byte lines driven in disable state");
	AST_VERIFY: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		(!pins_r.read_select_n && pins_r.vpp_high && !pins_r.test_mode_select)
		|-> pins_r.program_strobe_n && oe_r == 8'h00)
		else $error("verify levels wrong");
	AST_READ: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		(state_r == EPP_PULSE && req_r.op == EPP_OP_READ)
		|-> !pins_r.vpp_high && !pins_r.chip_select_n)
		else $error("read with vpp applied");
	AST_PROT_PROG: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		(oe_r[`EPP_BIT_Q8] && !dout_r[`EPP_BIT_Q8] && pins_r.test_mode_select)
		|-> pins_r.chip_select_n && pins_r.byte_addr[`EPP_BIT_A4])
		else $error("protect pulse levels wrong");
	AST_PROT_VER: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		(pins_r.test_mode_select && !pins_r.chip_select_n)
		|-> !pins_r.byte_addr[`EPP_BIT_A6] && !pins_r.read_select_n
		&& !pins_r.vpp_high)
		else $error("protect verify levels wrong");
	AST_PROC_HELD: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		!pins_r.processor_reset_n && !pins_r.processor_clock_in)
		else $error("processor not held low");
	AST_DONE: assert property (@(posedge core_clk_in) disable iff (!rst_r)
		(state_r == EPP_DONE) |=> done_out ##1 !done_out)
		else $error("done not one pulse");
endmodule

// file: epp_dev_model.sv
// behavioural model of the on-chip eprom cell seen through its programming pins
`timescale 1ns/1ps
module epp_dev_model
	import epp_pkg::*;
(
	input wire epp_pkg::epp_pins_t pins_in,
	input wire logic [7:0] lines_in,
	output logic [7:0] q_out,
	output logic q_oe_out
);
	import epp_pkg::*;
	// ----------------------------------------
	// cell array and protect state
	// ----------------------------------------
	logic [7:0] mem [0:8191];
	logic prot_r;
	// mode decode from the pin levels
	wire sel_rd = !pins_in.chip_select_n && !pins_in.read_select_n;
	wire rd_mode = sel_rd && pins_in.program_strobe_n && !pins_in.test_mode_select;
	wire pv_mode = sel_rd && pins_in.test_mode_select && !pins_in.byte_addr[6];
	wire pp_mode = pins_in.chip_select_n && pins_in.read_select_n && pins_in.program_strobe_n
		&& pins_in.test_mode_select && pins_in.vpp_high && pins_in.byte_addr[4];
	// erased cell: every bit one, protect bit clear
	initial
	begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'hff;
		prot_r = 1'b0;
	end
	// write only with select and strobe low; ones can only drop to zero
	always @(negedge pins_in.program_strobe_n)
		if (!pins_in.chip_select_n && pins_in.read_select_n && pins_in.vpp_high)
			mem[pins_in.byte_addr] = mem[pins_in.byte_addr] & lines_in;
	// protect bit set by a low pulse on the top line; no path clears it
	always @(negedge lines_in[7])
		if (pp_mode)
			prot_r = 1'b1;
	// refused or floated lines show the inverted cell byte, never the stored one
	assign q_oe_out = pv_mode || (rd_mode && !prot_r);
	assign q_out = pv_mode ? {~prot_r, 7'h7f} :
		(q_oe_out ? mem[pins_in.byte_addr] : ~mem[pins_in.byte_addr]);
endmodule

// file: epp_ctrl_bench.sv
// self-checking bench for the eprom programming controller
`timescale 1ns/1ps
module epp_ctrl_bench;
	import epp_pkg::*;
	logic clk;
	logic resetn;
	logic req_valid;
	epp_req_t req;
	logic ready, done, mism;
	logic [7:0] rd_data, ctl_q, ctl_oe, dev_q, lines;
	logic dev_oe;
	epp_pins_t pins, snap;
	logic [7:0] snap_oe, snap_q;
	int fails, cmp_count;
	// ----------------------------------------
	// design, partner and wire resolution
	// ----------------------------------------
	assign lines = (ctl_oe & ctl_q) | (~ctl_oe & dev_q);
	epp_ctrl epp_ctrl_i (.core_clk_in(clk), .resetn_in(resetn), .req_valid_in(req_valid),
		.req_in(req), .byte_lines_in(lines), .req_ready_out(ready), .done_out(done),
		.rd_data_out(rd_data), .mismatch_out(mism), .pins_out(pins),
		.byte_lines_out(ctl_q), .byte_lines_oe_out(ctl_oe));
	epp_dev_model epp_dev_model_i (.pins_in(pins), .lines_in(lines), .q_out(dev_q),
		.q_oe_out(dev_oe));
	// clock at 20 MHz
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one request; snapshot of the pins taken mid setup
	task automatic run_op(input epp_op_t op, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("ready", 8'h01, {7'h00, ready});
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d};
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		snap = pins;
		snap_oe = ctl_oe;
		snap_q = ctl_q;
		n = 0;
		while (done !== 1'b1 && n < 25000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("done", 8'h01, {7'h00, done});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_program_verify();
		run_op(EPP_OP_PROGRAM, 13'h1fff, 8'ha5);
		chk("prog cs oe pgm vpp", 8'h07, {4'h0, snap.chip_select_n,
			snap.read_select_n, snap.program_strobe_n, snap.vpp_high});
		chk("prog drive", 8'hff, snap_oe);
		chk("prog byte", 8'ha5, snap_q);
		chk("prog test rst clk", 8'h00, {5'h0, snap.test_mode_select,
			snap.processor_reset_n, snap.processor_clock_in});
		run_op(EPP_OP_VERIFY, 13'h1fff, 8'ha5);
		chk("verify vpp pgm", 8'h03, {6'h0, snap.vpp_high, snap.program_strobe_n});
		chk("verify data", 8'ha5, rd_data);
		chk("verify mismatch", 8'h00, {7'h0, mism});
	endtask
	task automatic t_reprogram();
		run_op(EPP_OP_PROGRAM, 13'h1fff, 8'h0f);
		run_op(EPP_OP_READ, 13'h1fff, 8'h00);
		chk("read vpp cs", 8'h00, {6'h0, snap.vpp_high, snap.chip_select_n});
		chk("one to zero only", 8'h05, rd_data);
		run_op(EPP_OP_VERIFY, 13'h1fff, 8'h0f);
		chk("verify differs", 8'h01, {7'h0, mism});
		run_op(EPP_OP_READ, 13'h0000, 8'h00);
		chk("erased byte", 8'hff, rd_data);
	endtask
	task automatic t_disable();
		run_op(EPP_OP_DISABLE, 13'h0000, 8'h00);
		chk("disable cs oe", 8'h03, {6'h0, snap.chip_select_n, snap.read_select_n});
		chk("disable float", 8'h00, snap_oe);
	endtask
	task automatic t_protect();
		run_op(EPP_OP_PROT_VERIFY, 13'h0000, 8'h00);
		chk("pv levels", 8'h02, {6'h0, snap.test_mode_select, snap.byte_addr[6]});
		chk("pv open", 8'h01, {7'h0, rd_data[7]});
		run_op(EPP_OP_PROT_PROG, 13'h0000, 8'h00);
		chk("pp levels", 8'h3f, {2'h0, snap.chip_select_n, snap.read_select_n,
			snap.program_strobe_n, snap.test_mode_select, snap.vpp_high,
			snap.byte_addr[4]});
		chk("pp drive", 8'h80, snap_oe);
		chk("pp q8 high before pulse", 8'h80, snap_q & 8'h80);
		run_op(EPP_OP_PROT_VERIFY, 13'h0000, 8'h00);
		chk("pv closed", 8'h00, {7'h0, rd_data[7]});
		run_op(EPP_OP_VERIFY, 13'h1fff, 8'h05);
		chk("verify refused", 8'h01, {7'h0, mism});
		run_op(EPP_OP_READ, 13'h1fff, 8'h00);
		chk("read refused", 8'h00, {7'h0, rd_data === 8'h05});
	endtask
	// ----------------------------------------
	// closing, watchdog and main sequence
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// long program pulses dominate; three of them plus short ops fit in this span
	initial
	begin
		#(75000 * 50);
		fails++;
		complete_run();
	end
	initial
	begin
		resetn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		fails = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		t_program_verify();
		t_reprogram();
		t_disable();
		t_protect();
		complete_run();
	end
endmodule
